// File: design/dscw_control.v
// What this block does
// - Command bit 10 hands both command and reference channel to the bus.
// - State bit 0 is set in ready or on, with mains and init present and pulses off.
// - State bit 1 shows the switched-on condition asked by command bit 0.
// - State bit 2 is set only while running, tracking, stage enabled.
// - State bit 2 clears when the stage is off or not tracking.
// - State bit 3 is set from an error until a successful fault reset, response by type.
// - A fault reset succeeds only once the error cause is gone.
// - After reset, a power trip goes to inhibit, else back to operation.
// - State bit 4 reads 0 under coast stop and 1 otherwise.
// - A fault reset acts on the rising edge of command bit 7 only.
// - Command bit 0 switches on; clearing it ramps down then powers off from run, at once from on.
// - Command bit 1 low drops power at once and enters inhibit.
`include "dscw_regs.vh"
`default_nettype none

module dscw_control (
    input wire clk_in,
    input wire reset_in,
    input wire [15:0] cmd_word_in,
    input wire cmd_write_in,
    input wire [3:0] local_cmd_in,
    input wire mains_ok_in,
    input wire init_done_in,
    input wire error_in,
    input wire error_trip_in,
    input wire standstill_in,
    input wire tracking_in,
    output reg [15:0] cmd_readback_out,
    output reg [15:0] state_word_out,
    output reg bus_cmd_active_out,
    output reg bus_ref_active_out,
    output reg power_enable_out,
    output reg pulse_enable_out,
    output reg ramp_down_out,
    output reg switch_inhibit_out
);
    // ************************************************************
    // States.
    // ************************************************************
    localparam [6:0] ST_NOT_READY = 7'h01;
    localparam [6:0] ST_INHIBIT = 7'h02;
    localparam [6:0] ST_READY = 7'h04;
    localparam [6:0] ST_ON = 7'h08;
    localparam [6:0] ST_RUN = 7'h10;
    localparam [6:0] ST_RAMP = 7'h20;
    localparam [6:0] ST_FAULT = 7'h40;

    reg [15:0] cmd_word;
    reg reset_bit_prev;
    reg [6:0] state;
    reg [6:0] next_state;
    reg trip_latched;
    reg next_trip_latched;
    reg [15:0] next_state_word;
    wire [`DSCW_IN_COUNT-1:0] raw_inputs;
    wire [`DSCW_IN_COUNT-1:0] synced;
    wire bus_ctrl;
    wire [3:0] eff_cmd;
    wire cmd_on;
    wire cmd_no_coast;
    wire cmd_enable;
    wire fault_reset_edge;
    wire powered_up;
    wire error_now;
    wire standstill_now;
    wire tracking_now;
    wire trip_now;
    wire in_ready;
    wire in_on;
    wire in_run;
    wire in_fault;
    reg next_power_enable;
    reg next_pulse_enable;
    reg next_ramp_down;
    reg next_switch_inhibit;

    // ************************************************************
    // Drive-side input synchronisers.
    // ************************************************************
    assign raw_inputs = {tracking_in, standstill_in, error_trip_in,
                         error_in, init_done_in, mains_ok_in};

    // Every drive input comes from another domain, so each is filtered.
    genvar gi;
    generate
        for (gi = 0; gi < `DSCW_IN_COUNT; gi = gi + 1) begin : g_sync
            dscw_sync u_sync (
                .clk_in(clk_in),
                .reset_in(reset_in),
                .async_in(raw_inputs[gi]),
                .sync_out(synced[gi])
            );
        end
    endgenerate

    assign powered_up = synced[`DSCW_IN_MAINS] & synced[`DSCW_IN_INIT];
    assign error_now = synced[`DSCW_IN_ERROR];
    assign standstill_now = synced[`DSCW_IN_STANDSTILL];
    assign tracking_now = synced[`DSCW_IN_TRACKING];
    assign trip_now = synced[`DSCW_IN_TRIP];

    // ************************************************************
    // Command word register.
    // ************************************************************
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            // Masking on entry keeps reserved positions zero on readback.
            cmd_word <= `DSCW_CMD_RESET;
            reset_bit_prev <= 1'b0;
        end else begin
            if (cmd_write_in) begin
                cmd_word <= cmd_word_in & `DSCW_CMD_MASK;
            end
            reset_bit_prev <= cmd_word[`DSCW_CMD_FAULT_RESET];
        end
    end

    // Level on bit 7 does nothing; only the 0 to 1 change counts.
    // The history bit resets to the idle level, so reset makes no edge.
    assign fault_reset_edge = cmd_word[`DSCW_CMD_FAULT_RESET] &
                              ~reset_bit_prev;

    // With bus control off, the local command source takes over.
    assign bus_ctrl = cmd_word[`DSCW_CMD_BUS_CTRL];
    assign eff_cmd = bus_ctrl ? cmd_word[3:0] : local_cmd_in;
    assign cmd_on = eff_cmd[`DSCW_CMD_ON];
    assign cmd_no_coast = eff_cmd[`DSCW_CMD_NO_COAST];
    assign cmd_enable = eff_cmd[`DSCW_CMD_ENABLE];

    // ************************************************************
    // Operating state machine.
    // ************************************************************
    always @* begin
        next_state = state;
        next_trip_latched = trip_latched;
        case (state)
            ST_NOT_READY: begin
                // Leaves once mains and electronics are both up; an error still forces fault.
                if (powered_up) begin
                    next_state = ST_INHIBIT;
                end
            end
            ST_INHIBIT: begin
                // A switch-on left standing must be withdrawn before arming.
                if (cmd_no_coast && !cmd_on) begin
                    next_state = ST_READY;
                end
            end
            ST_READY: begin
                // Armed; the switch-on command brings up the power stage.
                if (!cmd_no_coast) begin
                    next_state = ST_INHIBIT;
                end else if (cmd_on) begin
                    next_state = ST_ON;
                end
            end
            ST_ON: begin
                // Power is live while the pulses wait for the enable.
                if (!cmd_no_coast) begin
                    next_state = ST_INHIBIT;
                end else if (!cmd_on) begin
                    next_state = ST_READY;
                end else if (cmd_enable) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                // Dropping the enable keeps power but stops the pulses.
                if (!cmd_no_coast) begin
                    next_state = ST_INHIBIT;
                end else if (!cmd_on) begin
                    next_state = ST_RAMP;
                end else if (!cmd_enable) begin
                    next_state = ST_ON;
                end
            end
            ST_RAMP: begin
                // The ramp is interruptible by a fresh switch-on.
                if (!cmd_no_coast) begin
                    next_state = ST_INHIBIT;
                end else if (cmd_on) begin
                    next_state = ST_ON;
                end else if (standstill_now) begin
                    next_state = ST_READY;
                end
            end
            ST_FAULT: begin
                // Only a fresh reset edge with the cause gone leaves here.
                if (fault_reset_edge && !error_now) begin
                    if (trip_latched) begin
                        next_state = ST_INHIBIT;
                    end else begin
                        next_state = ST_RUN;
                    end
                end
            end
            default: begin
                next_state = ST_NOT_READY;
            end
        endcase

        // An error overrides every command; its type picks the path out.
        if (error_now && state != ST_FAULT) begin
            next_state = ST_FAULT;
            next_trip_latched = trip_now;
        end else if (!powered_up && state != ST_FAULT) begin
            next_state = ST_NOT_READY;
        end
    end

    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state <= ST_NOT_READY;
            trip_latched <= 1'b0;
        end else begin
            state <= next_state;
            trip_latched <= next_trip_latched;
        end
    end

    // ************************************************************
    // State decode.
    // ************************************************************
    assign in_ready = (state == ST_READY);
    assign in_on = (state == ST_ON);
    assign in_run = (state == ST_RUN);
    assign in_fault = (state == ST_FAULT);

    // ************************************************************
    // Power path decode.
    // ************************************************************
    always @* begin
        next_power_enable = 1'b0;
        next_pulse_enable = 1'b0;
        next_ramp_down = 1'b0;
        next_switch_inhibit = 1'b0;
        case (state)
            ST_INHIBIT: begin
                next_switch_inhibit = 1'b1;
            end
            ST_ON: begin
                next_power_enable = 1'b1;
            end
            ST_RUN: begin
                next_power_enable = 1'b1;
                next_pulse_enable = 1'b1;
            end
            ST_RAMP: begin
                // Power stays until standstill, then the stage drops.
                next_power_enable = 1'b1;
                next_pulse_enable = 1'b1;
                next_ramp_down = 1'b1;
            end
            default: begin
                // Coast stop, fault and not-ready all leave power off.
                next_power_enable = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // State word assembly.
    // ************************************************************
    always @* begin
        next_state_word = `DSCW_ST_RESET;
        // Pulses must be off for bit 0, which both states already imply.
        next_state_word[`DSCW_ST_READY_ON] = powered_up &&
            !next_pulse_enable && (in_ready || in_on);
        next_state_word[`DSCW_ST_READY_OP] = in_on || in_run;
        next_state_word[`DSCW_ST_OP_ENABLED] = in_run &&
            cmd_enable && tracking_now;
        next_state_word[`DSCW_ST_ERROR] = in_fault;
        next_state_word[`DSCW_ST_NO_COAST] = cmd_no_coast;
    end

    // ************************************************************
    // Registered outputs.
    // ************************************************************
    // Every output is a flop, so the far side never sees decode glitches.
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            cmd_readback_out <= `DSCW_CMD_RESET;
            state_word_out <= `DSCW_ST_RESET;
            bus_cmd_active_out <= 1'b0;
            bus_ref_active_out <= 1'b0;
            power_enable_out <= 1'b0;
            pulse_enable_out <= 1'b0;
            ramp_down_out <= 1'b0;
            switch_inhibit_out <= 1'b0;
        end else begin
            cmd_readback_out <= cmd_word;
            state_word_out <= next_state_word;
            bus_cmd_active_out <= bus_ctrl;
            bus_ref_active_out <= bus_ctrl;
            power_enable_out <= next_power_enable;
            pulse_enable_out <= next_pulse_enable;
            ramp_down_out <= next_ramp_down;
            switch_inhibit_out <= next_switch_inhibit;
        end
    end
endmodule // dscw_control

`default_nettype wire

// File: pkg/dscw_regs.vh
`ifndef DSCW_REGS_VH
`define DSCW_REGS_VH

// ****************************************************************
// Command word field positions.
// ****************************************************************
`define DSCW_CMD_ON 0
`define DSCW_CMD_NO_COAST 1
`define DSCW_CMD_NO_QSTOP 2
`define DSCW_CMD_ENABLE 3
`define DSCW_CMD_FAULT_RESET 7
`define DSCW_CMD_BUS_CTRL 10

// Writable command bits; 9 and 11 to 15 never store.
`define DSCW_CMD_MASK 16'h05FF
`define DSCW_CMD_RESET 16'h0000

// ****************************************************************
// State word field positions.
// ****************************************************************
`define DSCW_ST_READY_ON 0
`define DSCW_ST_READY_OP 1
`define DSCW_ST_OP_ENABLED 2
`define DSCW_ST_ERROR 3
`define DSCW_ST_NO_COAST 4
`define DSCW_ST_RESET 16'h0000

// ****************************************************************
// Synchronised drive input positions.
// ****************************************************************
`define DSCW_IN_MAINS 0
`define DSCW_IN_INIT 1
`define DSCW_IN_ERROR 2
`define DSCW_IN_TRIP 3
`define DSCW_IN_STANDSTILL 4
`define DSCW_IN_TRACKING 5
`define DSCW_IN_COUNT 6

`endif

// File: design/dscw_sync.v
`default_nettype none

// ****************************************************************
// Three-stage input synchroniser with agreement filter.
// ****************************************************************
module dscw_sync (
    input wire clk_in,
    input wire reset_in,
    input wire async_in,
    output reg sync_out
);
    reg stage1;
    reg stage2;
    reg stage3;

    // The filtered level only follows once stages two and three agree.
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                sync_out <= stage3;
            end
        end
    end
endmodule // dscw_sync

`default_nettype wire

// File: tb/dscw_control_properties.sv
`default_nettype none
// ************************
// Port checker.
// ************************
module dscw_props (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [15:0] cmd_word_in,
    input wire logic cmd_write_in,
    input wire logic [15:0] cmd_readback_out,
    input wire logic [15:0] state_word_out,
    input wire logic bus_cmd_active_out,
    input wire logic bus_ref_active_out,
    input wire logic power_enable_out,
    input wire logic pulse_enable_out,
    input wire logic ramp_down_out,
    input wire logic switch_inhibit_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    sequence s_write;
        cmd_write_in ##2 1'b1;
    endsequence
    sequence s_coast;
        cmd_write_in && cmd_word_in[10] && !cmd_word_in[1];
    endsequence
    a_write_readback: assert property (s_write |->
        cmd_readback_out == ($past(cmd_word_in, 2) & 16'h05FF))
        else $error("readback differs from masked write");
    a_reserved_zero: assert property (cmd_readback_out[15:11] == 5'h00
        && !cmd_readback_out[9] && state_word_out[15:5] == 11'h000)
        else $error("reserved bit set");
    a_bus_channels: assert property (bus_cmd_active_out ==
        bus_ref_active_out && bus_cmd_active_out == cmd_readback_out[10])
        else $error("bus channel flags disagree");
    a_ready_no_pulse: assert property (state_word_out[0] |->
        !pulse_enable_out && !state_word_out[2])
        else $error("ready to switch on with pulses");
    a_ready_op_power: assert property (state_word_out[1] |->
        power_enable_out) else $error("ready to operate without power");
    a_opena_running: assert property (state_word_out[2] |->
        pulse_enable_out && !ramp_down_out)
        else $error("operation enabled while not running");
    a_error_no_run: assert property (state_word_out[3] |->
        !state_word_out[2] && !power_enable_out)
        else $error("error with power on");
    a_inhibit_off: assert property (switch_inhibit_out |->
        !power_enable_out && !state_word_out[0])
        else $error("inhibit with power or ready");
    a_ramp_power: assert property (ramp_down_out |->
        power_enable_out && pulse_enable_out)
        else $error("ramp down without power");
    a_coast_drop: assert property (s_coast |->
        ##[3:4] !power_enable_out) else $error("coast stop kept power");
endmodule // dscw_props
bind dscw_control dscw_props u_props (.clk_in, .reset_in, .cmd_word_in,
    .cmd_write_in, .cmd_readback_out, .state_word_out,
    .bus_cmd_active_out, .bus_ref_active_out, .power_enable_out,
    .pulse_enable_out, .ramp_down_out, .switch_inhibit_out);
`default_nettype wire

// File: tb/dscw_bus_host.sv
`default_nettype none
// ************************
// Fieldbus controller.
// ************************
module dscw_bus_host (
    input wire logic clk_in,
    output logic [15:0] cmd_word_out,
    output logic cmd_write_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        cmd_word_out = 16'hFFFF;
        cmd_write_out = 1'b0;
    end
    // Between strobes the word carries the inverse of the last value.
    task automatic put_word(input logic [15:0] w);
        @(posedge clk_in);
        cmd_word_out <= w;
        cmd_write_out <= 1'b1;
        @(posedge clk_in);
        cmd_write_out <= 1'b0;
        cmd_word_out <= ~w;
    endtask
    task automatic fault_reset(input logic [15:0] w);
        put_word(w & 16'hFF7F);
        put_word(w | 16'h0080);
    endtask
endmodule // dscw_bus_host
`default_nettype wire

// File: tb/dscw_control_tb.sv
`default_nettype none
// ************************
// Command and state bench.
// ************************
module dscw_control_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [3:0] local_cmd = 4'h0;
    logic [5:0] env = 6'h23;
    wire logic [15:0] word, rb, state;
    wire logic wr_s, b_c, b_r, pw, pu, rd, inh;
    wire logic [15:0] flags = {10'h000, b_c, b_r, pw, pu, rd, inh};
    int err_count = 0;
    int checks = 0;
    initial begin
        forever #4 clk_in = ~clk_in;
    end
    dscw_bus_host u_host (.clk_in(clk_in), .cmd_word_out(word),
        .cmd_write_out(wr_s));
    dscw_control DUT (.clk_in(clk_in), .reset_in(reset_in),
        .cmd_word_in(word), .cmd_write_in(wr_s), .local_cmd_in(local_cmd),
        .mains_ok_in(env[0]), .init_done_in(env[1]), .error_in(env[2]),
        .error_trip_in(env[3]), .standstill_in(env[4]),
        .tracking_in(env[5]), .cmd_readback_out(rb), .state_word_out(state),
        .bus_cmd_active_out(b_c), .bus_ref_active_out(b_r),
        .power_enable_out(pw), .pulse_enable_out(pu), .ramp_down_out(rd),
        .switch_inhibit_out(inh));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] w, input bit fr);
        if (fr) u_host.fault_reset(w);
        else u_host.put_word(w);
        repeat (5) @(posedge clk_in);
        #1;
    endtask
    task automatic setenv(input logic [5:0] v);
        @(posedge clk_in);
        env <= v;
        repeat (8) @(posedge clk_in);
        #1;
    endtask
    task automatic setloc(input logic [3:0] v);
        @(posedge clk_in);
        local_cmd <= v;
        repeat (5) @(posedge clk_in);
        #1;
    endtask
    task automatic complete_run;
        $display("err_count=%0d checks=%0d", err_count, checks);
        if (err_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #20000;
        err_count++;
        complete_run();
    end
    initial begin
        repeat (6) @(posedge clk_in);
        reset_in <= 1'b0;
        #1;
        chk(state, 16'h0000);
        chk(rb, 16'h0000);
        setenv(6'h23);
        chk(flags, 16'h0001);
        chk(state, 16'h0000);
        wr(16'hFE02, 0);
        chk(rb, 16'h0402);
        chk(state, 16'h0011);
        chk(flags, 16'h0030);
        wr(16'h0403, 0);
        chk(state, 16'h0013);
        chk(flags, 16'h0038);
        wr(16'h040B, 0);
        chk(state, 16'h0016);
        setenv(6'h03);
        chk(state, 16'h0012);
        setenv(6'h23);
        wr(16'h040A, 0);
        chk(flags, 16'h003E);
        setenv(6'h33);
        chk(state, 16'h0011);
        setenv(6'h23);
        wr(16'h0403, 0);
        wr(16'h040B, 0);
        setenv(6'h27);
        chk(state & 16'h000C, 16'h0008);
        chk(flags & 16'h000C, 16'h0000);
        wr(16'h040B, 1);
        chk(state & 16'h0008, 16'h0008);
        setenv(6'h23);
        wr(16'h048B, 0);
        chk(state & 16'h0008, 16'h0008);
        wr(16'h040B, 1);
        chk(state, 16'h0016);
        setenv(6'h2F);
        setenv(6'h2B);
        wr(16'h040B, 1);
        chk(flags, 16'h0031);
        wr(16'h0402, 0);
        wr(16'h0403, 0);
        wr(16'h0401, 0);
        chk(state, 16'h0000);
        chk(flags, 16'h0031);
        wr(16'h0002, 0);
        chk(flags, 16'h0001);
        setloc(4'h2);
        chk(state, 16'h0011);
        setloc(4'h3);
        chk(state, 16'h0013);
        setloc(4'hB);
        chk(state, 16'h0016);
        setloc(4'h3);
        chk(state, 16'h0013);
        chk(flags, 16'h0008);
        setloc(4'hB);
        setloc(4'hA);
        chk(flags, 16'h000E);
        setloc(4'h3);
        chk(state, 16'h0013);
        setloc(4'h2);
        chk(state, 16'h0011);
        setloc(4'hB);
        setloc(4'h9);
        chk(flags, 16'h0001);
        chk(state, 16'h0000);
        setloc(4'h2);
        setenv(6'h22);
        chk(state, 16'h0010);
        chk(flags, 16'h0000);
        setenv(6'h23);
        chk(state, 16'h0011);
        @(posedge clk_in);
        reset_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b0;
        #1;
        chk(state, 16'h0000);
        chk(flags, 16'h0000);
        chk(rb, 16'h0000);
        setenv(6'h23);
        chk(state, 16'h0011);
        complete_run();
    end
endmodule // dscw_control_tb
`default_nettype wire
